// [design/mbr_register_map.sv]
// Network register map of the drive: command, reference, status and parameter access
`timescale 1ns/1ns
`include "mbr_regs.svh"

module mbr_register_map (
    input wire logic clock, // 10 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic req_valid, // One-cycle strobe of a decoded request beat
    input wire mbr_pkg::mbr_req_s req, // Function, address and data of the beat
    output logic resp_valid, // One-cycle strobe of the answer
    output mbr_pkg::mbr_resp_s resp, // Answer: data or exception
    input wire mbr_pkg::mbr_core_s core, // State from the motor control core
    input wire logic din1_pin, // Digital input one, asynchronous pin
    input wire logic din2_pin, // Digital input two, asynchronous pin
    output mbr_pkg::mbr_cmd_s cmd, // Decoded commands to the core
    output logic [15:0] speed_reference // Network speed reference, 0.1 Hz units
);
    import mbr_pkg::*;

    // ======================================================================
    // Storage
    // ======================================================================
    logic [15:0] drive_command_word;
    logic [15:0] network_speed_reference;
    logic [15:0] param [`MBR_PARAM_COUNT];

    // Pin synchronisers
    logic [1:0] din1_sync;
    logic [1:0] din2_sync;
    logic [15:0] drive_status_word;
    logic is_read;
    logic is_write;
    logic start_by_net;
    logic speed_by_net;
    logic [7:0] pidx;
    logic in_param;
    logic relay_by_net;

    // Decode results
    logic next_exception;
    logic [7:0] next_exc_code;
    logic [15:0] next_data;
    logic wr_command;
    logic wr_speed;
    logic wr_param;

    // ======================================================================
    // Decode helpers
    // ======================================================================
    // Selections are compared against the network port setting every cycle
    assign is_read = req.func == `MBR_FC_READ_HOLDING;
    assign is_write = (req.func == `MBR_FC_WRITE_SINGLE) || (req.func == `MBR_FC_WRITE_MULTI);
    assign start_by_net = param[`MBR_PARAM_START_SRC] == `MBR_SEL_NETWORK;
    assign speed_by_net = param[`MBR_PARAM_SPEED_SEL] == `MBR_SEL_NETWORK;
    assign pidx = req.addr[7:0];
    assign in_param = req.addr < `MBR_PARAM_LIMIT;
    assign relay_by_net = param[`MBR_PARAM_RELAY_SEL] == `MBR_RELAY_BY_NETWORK;

    // Digital input pins cross into the clock domain through two flops
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            din1_sync <= 2'h0;
            din2_sync <= 2'h0;
        end
        else
        begin
            // Only the second stage is read by logic
            din1_sync <= {din1_sync[0], din1_pin};
            din2_sync <= {din2_sync[0], din2_pin};
        end
    end

    // ======================================================================
    // Status word assembly
    // ======================================================================
    // Upper two bits are unused and held at zero
    always_comb
    begin
        drive_status_word = 16'h0000;
        drive_status_word[0] = core.ready;
        drive_status_word[1] = core.running;
        drive_status_word[2] = core.cmd_forward;
        drive_status_word[3] = core.rot_forward;
        drive_status_word[4] = core.accelerating;
        drive_status_word[5] = core.decelerating;
        drive_status_word[6] = core.alarm;
        drive_status_word[7] = core.faulted;
        drive_status_word[8] = core.at_reference;
        // Bits 9 and 10 follow the selection parameters, not the core
        drive_status_word[9] = speed_by_net;
        drive_status_word[10] = start_by_net;
        drive_status_word[11] = core.params_locked;
        // Pins are read only after both synchroniser stages
        drive_status_word[12] = din1_sync[1];
        drive_status_word[13] = din2_sync[1];
    end

    // ======================================================================
    // Request decode
    // ======================================================================
    // Address chain decides answer and which store, if any, is written
    always_comb
    begin
        next_exception = 1'b0;
        next_exc_code = 8'h00;
        next_data = 16'h0000;
        wr_command = 1'b0;
        wr_speed = 1'b0;
        wr_param = 1'b0;
        // Unknown function codes touch nothing
        if (!is_read && !is_write)
        begin
            next_exception = 1'b1;
            next_exc_code = `MBR_EXC_ILLEGAL_FUNC;
        end
        else if (req.addr == `MBR_ADDR_COMMAND)
        begin
            next_data = is_write ? req.data : drive_command_word;
            wr_command = is_write && start_by_net;
        end
        else if (req.addr == `MBR_ADDR_SPEED_REF)
        begin
            next_data = is_write ? req.data : network_speed_reference;
            wr_speed = is_write && speed_by_net;
        end
        // Read-only words answer reads only; writes fall to the refusal
        else if (req.addr == `MBR_ADDR_STATUS && is_read)
        begin
            next_data = drive_status_word;
        end
        else if (req.addr == `MBR_ADDR_FAULT && is_read)
        begin
            next_data = core.fault_code;
        end
        else if (req.addr == `MBR_ADDR_FEEDBACK && is_read)
        begin
            next_data = core.out_freq;
        end
        // Parameter 1 mirrors output frequency and cannot be written
        else if (in_param && pidx == `MBR_PARAM_OUT_FREQ && is_read)
        begin
            next_data = core.out_freq;
        end
        else if (in_param && pidx != `MBR_PARAM_OUT_FREQ)
        begin
            next_data = is_write ? req.data : param[pidx];
            wr_param = is_write;
        end
        else
        begin
            // Read-only targets and unmapped addresses end here
            next_exception = 1'b1;
            next_exc_code = `MBR_EXC_ILLEGAL_ADDR;
        end
    end

    // ======================================================================
    // Answer
    // ======================================================================
    // Answer follows each beat by exactly one cycle
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            resp_valid <= 1'b0;
            resp <= '0;
        end
        else
        begin
            resp_valid <= req_valid;
            if (req_valid)
            begin
                // Answer fields hold until the next beat is taken
                resp.exception <= next_exception;
                resp.func <= next_exception ? (req.func | `MBR_FC_EXC_FLAG) : req.func;
                resp.exc_code <= next_exc_code;
                resp.data <= next_data;
            end
        end
    end

    // ======================================================================
    // Network words
    // ======================================================================
    // Refused writes still echo, so the master sees no error, only no effect
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            drive_command_word <= `MBR_RESET_WORD;
        end
        else if (req_valid && wr_command)
        begin
            drive_command_word <= req.data;
        end
    end

    // Reference store, gated by its own selection parameter
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            network_speed_reference <= `MBR_RESET_WORD;
        end
        else if (req_valid && wr_speed)
        begin
            network_speed_reference <= req.data;
        end
    end

    // ======================================================================
    // Parameter store, one flop group per entry
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < `MBR_PARAM_COUNT; gi++)
        begin : g_param
            // Each entry loads only when its own index is addressed
            always_ff @(posedge clock)
            begin
                if (!reset_n)
                begin
                    param[gi] <= `MBR_RESET_WORD;
                end
                else if (req_valid && wr_param && pidx == 8'(gi))
                begin
                    param[gi] <= req.data;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Command decode toward the core
    // ======================================================================
    // Registered so the core sees glitch-free levels
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            cmd <= '0;
        end
        else
        begin
            // Single-bit requests pass straight through
            cmd.stop <= drive_command_word[`MBR_CMD_STOP];
            cmd.start <= drive_command_word[`MBR_CMD_START];
            cmd.jog <= drive_command_word[`MBR_CMD_JOG];
            cmd.clear_faults <= drive_command_word[`MBR_CMD_CLEAR];
            cmd.forward <= drive_command_word[`MBR_CMD_DIR_HI:`MBR_CMD_DIR_LO] == 2'h1;
            cmd.reverse <= drive_command_word[`MBR_CMD_DIR_HI:`MBR_CMD_DIR_LO] == 2'h2;
            // Relay level only counts while the network owns the relay
            cmd.relay_valid <= relay_by_net;
            cmd.relay_on <= relay_by_net && drive_command_word[`MBR_CMD_RELAY];
            cmd.mop_up <= drive_command_word[`MBR_CMD_MOP_UP];
            cmd.mop_down <= drive_command_word[`MBR_CMD_MOP_DOWN];
            // Two-bit fields: only the listed codes raise a level
            cmd.accel_rate1 <= drive_command_word[`MBR_CMD_ACC_HI:`MBR_CMD_ACC_LO] == 2'h1;
            cmd.accel_rate2 <= drive_command_word[`MBR_CMD_ACC_HI:`MBR_CMD_ACC_LO] == 2'h2;
            cmd.accel_hold <= drive_command_word[`MBR_CMD_ACC_HI:`MBR_CMD_ACC_LO] == 2'h3;
            cmd.decel_rate1 <= drive_command_word[`MBR_CMD_DEC_HI:`MBR_CMD_DEC_LO] == 2'h1;
            cmd.decel_rate2 <= drive_command_word[`MBR_CMD_DEC_HI:`MBR_CMD_DEC_LO] == 2'h2;
            cmd.decel_hold <= drive_command_word[`MBR_CMD_DEC_HI:`MBR_CMD_DEC_LO] == 2'h3;
            cmd.freq_source <= mbr_src_e'(drive_command_word[`MBR_CMD_SRC_HI:`MBR_CMD_SRC_LO]);
        end
    end

    // Reference copy toward the core, one edge behind the stored word
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            speed_reference <= `MBR_RESET_WORD;
        end
        else
        begin
            speed_reference <= network_speed_reference;
        end
    end

endmodule : mbr_register_map

// [design/mbr_regs.svh]
// Register offsets, field positions, reset values and codes of the drive network register map
`ifndef MBR_REGS_SVH
`define MBR_REGS_SVH

// ==========================================================================
// Function codes and exception codes
// ==========================================================================
`define MBR_FC_READ_HOLDING 8'h03
`define MBR_FC_WRITE_SINGLE 8'h06
`define MBR_FC_WRITE_MULTI 8'h10
`define MBR_FC_EXC_FLAG 8'h80
`define MBR_EXC_ILLEGAL_FUNC 8'h01
`define MBR_EXC_ILLEGAL_ADDR 8'h02

// ==========================================================================
// Register addresses (zero-based, as carried in the request)
// ==========================================================================
`define MBR_ADDR_COMMAND 16'h2000
`define MBR_ADDR_SPEED_REF 16'h2001
`define MBR_ADDR_STATUS 16'h2100
`define MBR_ADDR_FAULT 16'h2101
`define MBR_ADDR_FEEDBACK 16'h2103
`define MBR_PARAM_COUNT 256
`define MBR_PARAM_LIMIT 16'h0100
`define MBR_PARAM_OUT_FREQ 8'h01
`define MBR_PARAM_START_SRC 8'h6a
`define MBR_PARAM_SPEED_SEL 8'h6c
`define MBR_PARAM_RELAY_SEL 8'hdd

// ==========================================================================
// Selection values and reset values
// ==========================================================================
`define MBR_SEL_NETWORK 16'h0005
`define MBR_RELAY_BY_NETWORK 16'h000d
`define MBR_RESET_WORD 16'h0000

// ==========================================================================
// Command word fields
// ==========================================================================
`define MBR_CMD_STOP 0
`define MBR_CMD_START 1
`define MBR_CMD_JOG 2
`define MBR_CMD_CLEAR 3
`define MBR_CMD_DIR_LO 4
`define MBR_CMD_DIR_HI 5
`define MBR_CMD_RELAY 6
`define MBR_CMD_MOP_UP 7
`define MBR_CMD_ACC_LO 8
`define MBR_CMD_ACC_HI 9
`define MBR_CMD_DEC_LO 10
`define MBR_CMD_DEC_HI 11
`define MBR_CMD_SRC_LO 12
`define MBR_CMD_SRC_HI 14
`define MBR_CMD_MOP_DOWN 15

`endif

// [design/mbr_pkg.sv]
// Types shared by the drive network register map
package mbr_pkg;

    // ======================================================================
    // Decoded request beat and its answer
    // ======================================================================
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] data;
    } mbr_req_s;

    typedef struct packed {
        logic exception;
        logic [7:0] func;
        logic [7:0] exc_code;
        logic [15:0] data;
    } mbr_resp_s;

    // Frequency source selection, codes as carried in the command word
    typedef enum logic [2:0] {
        MBR_SRC_NONE = 3'h0,
        MBR_SRC_SPEED_PARAM = 3'h1,
        MBR_SRC_INTERNAL = 3'h2,
        MBR_SRC_NETWORK = 3'h3,
        MBR_SRC_PRESET0 = 3'h4,
        MBR_SRC_PRESET1 = 3'h5,
        MBR_SRC_PRESET2 = 3'h6,
        MBR_SRC_PRESET3 = 3'h7
    } mbr_src_e;

    // ======================================================================
    // Commands toward the motor control core
    // ======================================================================
    typedef struct packed {
        logic stop;
        logic start;
        logic jog;
        logic clear_faults;
        logic forward;
        logic reverse;
        logic relay_valid;
        logic relay_on;
        logic mop_up;
        logic mop_down;
        logic accel_rate1;
        logic accel_rate2;
        logic accel_hold;
        logic decel_rate1;
        logic decel_rate2;
        logic decel_hold;
        mbr_src_e freq_source;
    } mbr_cmd_s;

    // State reported by the motor control core
    typedef struct packed {
        logic ready;
        logic running;
        logic cmd_forward;
        logic rot_forward;
        logic accelerating;
        logic decelerating;
        logic alarm;
        logic faulted;
        logic at_reference;
        logic params_locked;
        logic [15:0] fault_code;
        logic [15:0] out_freq;
    } mbr_core_s;

endpackage : mbr_pkg

// [test/mbr_master_model.sv]
// Network master model issuing decoded register beats toward the map
`timescale 1ns/1ns

module mbr_master_model (
    input wire logic clock, // System clock
    output logic req_valid, // Request strobe
    output mbr_pkg::mbr_req_s req, // Request beat
    input wire logic resp_valid, // Answer strobe
    input wire mbr_pkg::mbr_resp_s resp // Answer
);
    import mbr_pkg::*;

    // Idle bus at time zero
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end

    // =====================================================================
    // One beat
    // =====================================================================
    // Drive after an edge, hold through the taking edge, then scramble the fields
    task xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, output logic got,
        output mbr_resp_s ans);
        @(posedge clock);
        #1;
        req_valid = 1'b1;
        req = '{func: f, addr: a, data: d}; // Zero-based address, codes 03/06/16 unless refused on purpose
        @(posedge clock);
        #1;
        got = resp_valid;
        ans = resp;
        req_valid = 1'b0;
        req = ~req; // Stale fields must not look like the last request
    endtask : xfer
endmodule : mbr_master_model

// [test/mbr_register_map_props.sv]
// Concurrent checks on the ports of the drive network register map
`timescale 1ns/1ns

module mbr_register_map_props (
    input wire logic clock, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic req_valid, // Request strobe
    input wire mbr_pkg::mbr_req_s req, // Request beat
    input wire logic resp_valid, // Answer strobe
    input wire mbr_pkg::mbr_resp_s resp, // Answer
    input wire mbr_pkg::mbr_core_s core, // Core state
    input wire logic din1_pin, // Digital input one
    input wire logic din2_pin, // Digital input two
    input wire mbr_pkg::mbr_cmd_s cmd, // Decoded commands
    input wire logic [15:0] speed_reference // Network speed reference
);
    import mbr_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // =====================================================================
    // Answer timing and refusals
    // =====================================================================
    AST_RESP_TIMING: assert property (req_valid |=> resp_valid)
        else $error("answer missing one cycle after request");
    AST_NO_SPURIOUS: assert property (resp_valid |-> $past(req_valid))
        else $error("answer without request");
    AST_ILLEGAL_FUNC: assert property (req_valid && !(req.func inside {8'h03, 8'h06, 8'h10}) |=>
        resp.exception && resp.exc_code == 8'h01 && resp.func == ($past(req.func) | 8'h80))
        else $error("unsupported code not refused");
    AST_RO_WRITE: assert property (req_valid && req.func == 8'h06 &&
        req.addr inside {16'h2100, 16'h2101, 16'h2103, 16'h0001} |=> resp.exception && resp.exc_code == 8'h02)
        else $error("write to read-only place not refused");
    AST_CMD_ECHO: assert property (req_valid && req.func == 8'h06 && req.addr == 16'h2000 |=>
        !resp.exception && resp.data == $past(req.data))
        else $error("command write not echoed");

    // =====================================================================
    // Read data and decoded levels
    // =====================================================================
    AST_STATUS_UNUSED: assert property (req_valid && req.func == 8'h03 && req.addr == 16'h2100 |=>
        resp.data[15:14] == 2'b00)
        else $error("unused status bits set");
    AST_FEEDBACK: assert property (req_valid && req.func == 8'h03 && req.addr == 16'h2103 |=>
        resp.data == $past(core.out_freq))
        else $error("feedback differs from output frequency");
    AST_FAULT: assert property (req_valid && req.func == 8'h03 && req.addr == 16'h2101 |=>
        resp.data == $past(core.fault_code))
        else $error("fault code differs from core");
    AST_DIR_EXCL: assert property ($onehot0({cmd.forward, cmd.reverse}))
        else $error("both directions commanded");
    AST_RAMP_EXCL: assert property ($onehot0({cmd.accel_rate1, cmd.accel_rate2, cmd.accel_hold}) &&
        $onehot0({cmd.decel_rate1, cmd.decel_rate2, cmd.decel_hold}))
        else $error("ramp selections overlap");
    AST_RELAY: assert property (cmd.relay_on |-> cmd.relay_valid)
        else $error("relay driven without network selection");
    // Reference may only move two edges after a write to its register
    AST_SPEED_HOLD: assert property ($changed(speed_reference) && $past(reset_n) |->
        $past(req_valid, 2) && $past(req.addr, 2) == 16'h2001)
        else $error("speed reference changed without write");

    // Main scenarios reached
    cover property (req_valid && req.func == 8'h10);
    cover property (resp_valid && resp.exception);
    cover property ($rose(cmd.relay_on));
endmodule : mbr_register_map_props

// [test/test_drive_modbus_register_map.sv]
// Self-checking bench of the drive network register map
`timescale 1ns/1ns

module test_drive_modbus_register_map;
    import mbr_pkg::*;

    // Request, expected exception flag, exception code and data
    typedef struct packed {
        logic [7:0] f;
        logic [15:0] a;
        logic [15:0] d;
        logic x;
        logic [7:0] c;
        logic [15:0] r;
    } mbr_row_s;

    localparam mbr_row_s rows [0:14] = '{
        '{8'h06, 16'h2000, 16'h0012, 1'b0, 8'h00, 16'h0012}, // Ignored, start source not network
        '{8'h03, 16'h2000, 16'h0000, 1'b0, 8'h00, 16'h0000},
        '{8'h06, 16'h006a, 16'h0005, 1'b0, 8'h00, 16'h0005},
        '{8'h06, 16'h006c, 16'h0005, 1'b0, 8'h00, 16'h0005},
        '{8'h06, 16'h00dd, 16'h000d, 1'b0, 8'h00, 16'h000d},
        '{8'h03, 16'h006a, 16'h0000, 1'b0, 8'h00, 16'h0005},
        '{8'h06, 16'h2001, 16'h021f, 1'b0, 8'h00, 16'h021f},
        '{8'h03, 16'h2001, 16'h0000, 1'b0, 8'h00, 16'h021f},
        '{8'h10, 16'h2000, 16'h0012, 1'b0, 8'h00, 16'h0012},
        '{8'h03, 16'h2000, 16'h0000, 1'b0, 8'h00, 16'h0012},
        '{8'h06, 16'h2100, 16'h1234, 1'b1, 8'h02, 16'h0000},
        '{8'h06, 16'h0001, 16'h1234, 1'b1, 8'h02, 16'h0000},
        '{8'h04, 16'h2000, 16'h0055, 1'b1, 8'h01, 16'h0000},
        '{8'h03, 16'h3000, 16'h0000, 1'b1, 8'h02, 16'h0000},
        '{8'h03, 16'h2000, 16'h0000, 1'b0, 8'h00, 16'h0012}
    };
    localparam logic [15:0] words [0:23] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
        16'h0020, 16'h0030, 16'h0040, 16'h0080, 16'h8000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0800,
        16'h0c00, 16'h1000, 16'h2000, 16'h3000, 16'h4000, 16'h5000, 16'h6000, 16'h7000};

    logic clock;
    logic reset_n;
    logic req_valid;
    mbr_req_s req;
    logic resp_valid;
    mbr_resp_s resp;
    mbr_core_s core;
    logic din1_pin;
    logic din2_pin;
    mbr_cmd_s cmd;
    logic [15:0] speed_reference;
    logic got;
    mbr_resp_s ans;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    mbr_register_map i_mbr_register_map (.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp(resp), .core(core), .din1_pin(din1_pin), .din2_pin(din2_pin), .cmd(cmd),
        .speed_reference(speed_reference));
    mbr_master_model i_mbr_master_model (.clock(clock), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp(resp));

    // =====================================================================
    // Helpers
    // =====================================================================
    task check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task rd(input logic [15:0] a, input logic [15:0] e);
        i_mbr_master_model.xfer(8'h03, a, 16'h0000, got, ans);
        check(40'(ans.data), 40'(e));
    endtask : rd

    // Expected decode worked out from the command word layout
    function automatic mbr_cmd_s exp_cmd(input logic [15:0] w, input logic rv);
        exp_cmd = '{w[0], w[1], w[2], w[3], w[5:4] == 2'b01, w[5:4] == 2'b10, rv, rv & w[6], w[7], w[15],
            w[9:8] == 2'b01, w[9:8] == 2'b10, w[9:8] == 2'b11, w[11:10] == 2'b01, w[11:10] == 2'b10,
            w[11:10] == 2'b11, mbr_src_e'(w[14:12])};
    endfunction : exp_cmd

    task results();
        $display("Checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // Free-running clock, 100 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Hang guard, far above the roughly 160 cycles the sequence needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            results();
        end
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial
    begin
        reset_n = 1'b0;
        core = '0;
        din1_pin = 1'b0;
        din2_pin = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check(40'({cmd, speed_reference}), 40'h0);
        foreach (rows[i])
        begin
            i_mbr_master_model.xfer(rows[i].f, rows[i].a, rows[i].d, got, ans);
            check(40'(got), 40'h1);
            check(40'({ans.exception, ans.func, ans.exc_code}), 40'({rows[i].x, rows[i].f | {rows[i].x, 7'h00}, rows[i].c}));
            if (!rows[i].x)
                check(40'(ans.data), 40'(rows[i].r));
        end
        check(40'(speed_reference), 40'h021f);
        // Every command field code, relay enabled by its selection
        foreach (words[i])
        begin
            i_mbr_master_model.xfer(8'h06, 16'h2000, words[i], got, ans);
            @(posedge clock);
            #1;
            check(40'(cmd), 40'(exp_cmd(words[i], 1'b1)));
        end
        i_mbr_master_model.xfer(8'h06, 16'h00dd, 16'h0000, got, ans);
        i_mbr_master_model.xfer(8'h06, 16'h2000, 16'h0040, got, ans);
        @(posedge clock);
        #1;
        check(40'(cmd), 40'(exp_cmd(16'h0040, 1'b0)));
        // Status, fault and feedback follow the core and pins
        core = {10'h3ff, 16'h0051, 16'h021f};
        din1_pin = 1'b1;
        din2_pin = 1'b1;
        repeat (3) @(posedge clock);
        rd(16'h2100, 16'h3fff);
        rd(16'h2101, 16'h0051);
        rd(16'h2103, 16'h021f);
        rd(16'h0001, 16'h021f);
        core = {10'h0aa, 16'h0000, 16'h0064};
        din2_pin = 1'b0;
        repeat (3) @(posedge clock);
        rd(16'h2100, 16'h1754);
        rd(16'h2101, 16'h0000);
        rd(16'h2103, 16'h0064);
        // Second reset clears selections, so command writes are ignored again
        reset_n = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check(40'({cmd, speed_reference}), 40'h0);
        i_mbr_master_model.xfer(8'h06, 16'h2000, 16'h0002, got, ans);
        rd(16'h2000, 16'h0000);
        i_mbr_master_model.xfer(8'h06, 16'h2001, 16'h0123, got, ans);
        check(40'(ans.data), 40'h0123);
        rd(16'h2001, 16'h0000);
        check(40'(speed_reference), 40'h0);
        results();
    end
endmodule : test_drive_modbus_register_map

bind mbr_register_map mbr_register_map_props i_mbr_register_map_props (.clock(clock), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .resp_valid(resp_valid), .resp(resp), .core(core), .din1_pin(din1_pin),
    .din2_pin(din2_pin), .cmd(cmd), .speed_reference(speed_reference));
